// [test_vcms_top.sv]
// Testbench for the vector mode selector
`include "vcms_defines.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module test_vcms_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, swap = 0, inh = 0, e;
  logic [15:0] freq = 0, ain = 0, clim = 0, fwc = 16'd80;
  logic [31:0] q;
  int error_cnt = 0, compares = 0;
  wire psel, pen, pwr, prdy, perr;
  wire [11:0] padr;
  wire [31:0] pwd, prd;
  wire tmode, rev, cs, isep;
  wire [1:0] fwm;
  wire [3:0] fwx;
  wire [15:0] kp, ti, mlim, blim, tref, exkp, slip, fwi;
  // ==========================================
  // Clock, reset and instances
  initial forever #25 clk = ~clk;
  vcms_host u_host (.clk_i(clk), .pready_i(prdy), .pslverr_i(perr), .prdata_i(prd),
    .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(padr), .pwdata_o(pwd));
  vcms_top u_dut (.CLK_SYS_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
    .PSLVERR_O(perr), .MODE_SWAP_I(swap), .TORQUE_INHIBIT_I(inh), .RUN_FREQ_I(freq),
    .ANALOG_IN_A_I(ain), .ANALOG_IN_B_I(16'h0), .ANALOG_IN_C_I(16'h0),
    .PULSE_INPUT_I(16'h0), .COMM_TORQUE_I(16'h0), .COMM_LIMIT_I(clim),
    .FW_CALC_CURRENT_I(fwc), .TORQUE_MODE_O(tmode), .SPEED_KP_O(kp), .SPEED_TI_O(ti),
    .INTEGRAL_SEP_O(isep), .EXCIT_KP_O(exkp), .EXCIT_KI_O(), .TORQUE_KP_O(), .TORQUE_KI_O(),
    .MOTORING_LIMIT_O(mlim), .BRAKING_LIMIT_O(blim), .SLIP_GAIN_O(slip), .FW_MODE_O(fwm),
    .FW_CURRENT_O(fwi), .FW_ADAPT_GAIN_O(), .FW_MULT_O(fwx), .TORQUE_REF_O(tref),
    .REVERSE_O(rev), .CYCLE_START_O(cs));
  // Two cycle starts so a mid cycle change has surely landed
  task sync;
    repeat (2) @(posedge cs);
    @(negedge clk);
  endtask
  task test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog sized well past the longest run
  initial
  begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    test_done;
  end
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    sync;
    `CHK(kp, 16'd30)
    `CHK(tmode, 1'b0)
    `CHK(mlim, 16'd1500)
    `CHK(isep, 1'b0)
    `CHK(blim, 16'd1500)
    `CHK(exkp, 16'd2000)
    `CHK(slip, 16'd100)
    `CHK(fwm, 2'd1)
    `CHK(fwx, 4'd2)
    `CHK(fwi, 16'd50)
    u_host.xfer(1'b0, `VCMS_OFF_FLO, 32'h0, q, e);
    `CHK(q, 32'd500)
    @(posedge clk) freq <= 16'd750;
    sync;
    `CHK(kp, 16'd25)
    `CHK(ti, 16'd75)
    @(posedge clk) freq <= 16'd1000;
    sync;
    `CHK(kp, 16'd20)
    @(posedge clk) clim <= 16'h4000;
    u_host.xfer(1'b1, `VCMS_OFF_MLSRC, 32'd5, q, e);
    u_host.xfer(1'b1, `VCMS_OFF_ISEP, 32'd1, q, e);
    sync;
    `CHK(mlim, 16'd750)
    `CHK(isep, 1'b1)
    u_host.xfer(1'b1, `VCMS_OFF_MODE, 32'd1, q, e);
    sync;
    `CHK(tmode, 1'b1)
    `CHK(tref, 16'd1000)
    @(posedge clk) swap <= 1'b1;
    sync;
    `CHK(tmode, 1'b0)
    @(posedge clk) inh <= 1'b1;
    swap <= 1'b0;
    sync;
    `CHK(tmode, 1'b0)
    @(posedge clk) inh <= 1'b0;
    ain <= 16'h4000;
    u_host.xfer(1'b1, `VCMS_OFF_TRSRC, 32'd1, q, e);
    u_host.xfer(1'b1, `VCMS_OFF_TRVAL, 32'h0000fe0c, q, e);
    sync;
    `CHK(tref, 16'hff06)
    `CHK(rev, 1'b1)
    u_host.xfer(1'b0, 12'h0f0, 32'h0, q, e);
    `CHK(e, 1'b1)
    u_host.xfer(1'b1, `VCMS_OFF_CTRL, 32'h3, q, e);
    repeat (4) @(negedge clk);
    `CHK(tmode, 1'b0)
    `CHK(tref, 16'h0)
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk) rstn <= 1'b1;
    sync;
    `CHK(mlim, 16'd1500)
    test_done;
  end
endmodule
bind vcms_top vcms_properties u_chk (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .PRDATA_O(PRDATA_O), .TORQUE_MODE_O(TORQUE_MODE_O), .MOTORING_LIMIT_O(MOTORING_LIMIT_O),
  .BRAKING_LIMIT_O(BRAKING_LIMIT_O), .TORQUE_REF_O(TORQUE_REF_O), .REVERSE_O(REVERSE_O),
  .SPEED_KP_O(SPEED_KP_O), .SPEED_TI_O(SPEED_TI_O), .CYCLE_START_O(CYCLE_START_O));

// [vcms_defines.vh]
// Register map, field layout, reset values and scaling constants of the vector mode selector
`ifndef VCMS_DEFINES_VH
`define VCMS_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define VCMS_OFF_MODE      12'h000
`define VCMS_OFF_KP_SET1   12'h004
`define VCMS_OFF_TI_SET1   12'h008
`define VCMS_OFF_FLO       12'h00c
`define VCMS_OFF_KP2       12'h010
`define VCMS_OFF_TI2       12'h014
`define VCMS_OFF_FHI       12'h018
`define VCMS_OFF_ISEP      12'h01c
`define VCMS_OFF_EXKP      12'h028
`define VCMS_OFF_EXKI      12'h02c
`define VCMS_OFF_TQKP      12'h030
`define VCMS_OFF_TQKI      12'h034
`define VCMS_OFF_MLSRC     12'h038
`define VCMS_OFF_BLSRC     12'h03c
`define VCMS_OFF_MLVAL     12'h040
`define VCMS_OFF_BLVAL     12'h044
`define VCMS_OFF_SLIP      12'h048
`define VCMS_OFF_FWMODE    12'h054
`define VCMS_OFF_FWDEPTH   12'h058
`define VCMS_OFF_FWMAX     12'h05c
`define VCMS_OFF_FWGAIN    12'h060
`define VCMS_OFF_FWMULT    12'h064
`define VCMS_OFF_TRSRC     12'h068
`define VCMS_OFF_TRVAL     12'h06c
`define VCMS_OFF_CTRL      12'h080
`define VCMS_OFF_STATUS    12'h084
`define VCMS_OFF_SPDKP     12'h088
`define VCMS_OFF_SPDTI     12'h08c
`define VCMS_OFF_MLIM      12'h090
`define VCMS_OFF_BLIM      12'h094
`define VCMS_OFF_TQREF     12'h098
`define VCMS_OFF_FWLIM     12'h09c

// ==========================================================================
// Reset values (units: gain x100, time 10 ms, freq 10 mHz, torque 0.1 %)
`define VCMS_RST_MODE      1'b0
`define VCMS_RST_KP_SET1   16'd30
`define VCMS_RST_TI_SET1   16'd50
`define VCMS_RST_FLO       16'd500
`define VCMS_RST_KP2       16'd20
`define VCMS_RST_TI2       16'd100
`define VCMS_RST_FHI       16'd1000
`define VCMS_RST_CURKP     16'd2000
`define VCMS_RST_CURKI     16'd1300
`define VCMS_RST_LIMVAL    16'd1500
`define VCMS_RST_SLIP      16'd100
`define VCMS_RST_FWMODE    2'd1
`define VCMS_RST_FWDEPTH   16'd100
`define VCMS_RST_FWMAX     16'd50
`define VCMS_RST_FWGAIN    16'd100
`define VCMS_RST_FWMULT    4'd2
`define VCMS_RST_TRVAL     16'sd1000
`define VCMS_RST_FMAX      16'd5000

// ==========================================================================
// Ranges
`define VCMS_KP_MIN        16'd1
`define VCMS_KP_MAX        16'd1000
`define VCMS_CUR_MAX       16'd30000
`define VCMS_LIM_MAX       16'd2000
`define VCMS_SLIP_MIN      16'd50
`define VCMS_SLIP_MAX      16'd200
`define VCMS_FWD_MIN       16'd50
`define VCMS_FWD_MAX       16'd500
`define VCMS_FWM_MIN       16'd1
`define VCMS_FWM_MAX       16'd300
`define VCMS_FWG_MIN       16'd10
`define VCMS_FWG_MAX       16'd500
`define VCMS_MUL_MIN       4'd2
`define VCMS_MUL_MAX       4'd10
`define VCMS_TRQ_MAX       16'sd2000
`define VCMS_SRC_MAX       3'd5
`define VCMS_FULL_SCALE    16'h7fff
`define VCMS_CYC_LEN       8'd200

// ==========================================================================
// Field positions
`define VCMS_CTRL_EN       0
`define VCMS_CTRL_VF       1
`define VCMS_CTRL_M2       2
`define VCMS_ST_ACTIVE     0
`define VCMS_ST_TORQUE     1
`define VCMS_ST_REV        2
`define VCMS_ST_SET2       3
`define VCMS_ST_INTERP     4

`endif

// [vcms_host.sv]
// Parameter host model speaking APB
module vcms_host
(
  // Bus inputs
  input  wire        clk_i,
  input  wire        pready_i,
  input  wire        pslverr_i,
  input  wire [31:0] prdata_i,
  // Bus outputs
  output logic        psel_o,
  output logic        penable_o,
  output logic        pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Idle bus at time zero
  initial
  begin
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  end
  // One transfer; data and error are taken at the edge that sees ready high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// [vcms_top.v]
// Vector control mode, gain schedule and torque limit/reference source selection
//
// Function
// - Settings act only for motor one under vector control, else outputs idle; here gains, slip, field weakening mode, gain and multiple keep their last values.
// - Mode selector 0 picks speed control, 1 torque control, default 0.
// - Active mode-swap input inverts the selector's mode.
// - Active torque-inhibit input forces speed control over everything else.
// - Frequency at or below low switchover uses gain set one.
// - Frequency at or above high switchover uses gain set two.
// - Between switchovers gains are linearly interpolated.
// - Low switchover lies in zero..high, high lies in low..max frequency.
// - Speed gains 0.01..10.00, integral times 0.01..10.00 s, given defaults.
// - Integral property 0 disables separation, 1 enables, default 0.
// - Current loop gains 0..30000, defaults 2000 and 1300, integral as gain.
// - Speed mode motoring limit from source 0..5, default digital.
// - Speed mode braking limit from own selector, same codes.
// - Source limits scale 100% to digital value; digital 0..200%, default 150%.
// - Slip gain 50..200%, default 100%.
// - Field weakening mode 0 off, 1 direct, 2 automatic, default 1.
// - Direct mode scales demagnetizing current by depth 50..500%.
// - Field weakening current limited by maximum setting 1..300%.
// - Adaptation gain 0.10..5.00 and integral multiple 2..10.
// - Torque reference source codes 0..7 including min and max of two analogs.
// - Full scale of sources 1..7 equals the torque digital setting.
// - Torque setting -200..200%, default 100%, sign gives direction.
//
// Design decisions made here: the register addresses and register access over APB.
`include "vcms_defines.vh"

module vcms_top
(
  // Clock and reset
  input  wire        CLK_SYS_I,
  input  wire        RESETN_I,
  // APB slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // Pins from outside the clock domain
  input  wire        MODE_SWAP_I,
  input  wire        TORQUE_INHIBIT_I,
  // Control side inputs (same clock)
  input  wire [15:0] RUN_FREQ_I,
  input  wire [15:0] ANALOG_IN_A_I,
  input  wire [15:0] ANALOG_IN_B_I,
  input  wire [15:0] ANALOG_IN_C_I,
  input  wire [15:0] PULSE_INPUT_I,
  input  wire [15:0] COMM_TORQUE_I,
  input  wire [15:0] COMM_LIMIT_I,
  input  wire [15:0] FW_CALC_CURRENT_I,
  // Control results
  output reg         TORQUE_MODE_O,
  output reg  [15:0] SPEED_KP_O,
  output reg  [15:0] SPEED_TI_O,
  output reg         INTEGRAL_SEP_O,
  output reg  [15:0] EXCIT_KP_O,
  output reg  [15:0] EXCIT_KI_O,
  output reg  [15:0] TORQUE_KP_O,
  output reg  [15:0] TORQUE_KI_O,
  output reg  [15:0] MOTORING_LIMIT_O,
  output reg  [15:0] BRAKING_LIMIT_O,
  output reg  [15:0] SLIP_GAIN_O,
  output reg  [1:0]  FW_MODE_O,
  output reg  [15:0] FW_CURRENT_O,
  output reg  [15:0] FW_ADAPT_GAIN_O,
  output reg  [3:0]  FW_MULT_O,
  output reg  [15:0] TORQUE_REF_O,
  output reg         REVERSE_O,
  output reg         CYCLE_START_O
);

  // ==========================================================================
  // Shadow registers written by software, except fmax_q, which keeps its reset value
  reg        mode_q;
  reg [15:0] kp_set1_q, ti_set1_q, flo_q, kp2_q, ti2_q, fhi_q;
  reg        isep_q;
  reg [15:0] exkp_q, exki_q, tqkp_q, tqki_q;
  reg [2:0]  mlsrc_q, blsrc_q, trsrc_q;
  reg [15:0] mlval_q, blval_q, slip_q;
  reg [1:0]  fwmode_q;
  reg [15:0] fwdepth_q, fwmax_q, fwgain_q;
  reg [3:0]  fwmult_q;
  reg [15:0] trval_q;
  reg [2:0]  ctrl_q;
  reg [15:0] fmax_q;

  wire wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  wire [15:0] wd = PWDATA_I[15:0];

  // Range clamp helper; out-of-range writes saturate instead of being dropped
  function [15:0] clampu;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // ==========================================================================
  // APB write path
  always @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      mode_q    <= `VCMS_RST_MODE;
      kp_set1_q <= `VCMS_RST_KP_SET1;
      ti_set1_q <= `VCMS_RST_TI_SET1;
      flo_q     <= `VCMS_RST_FLO;
      kp2_q     <= `VCMS_RST_KP2;
      ti2_q     <= `VCMS_RST_TI2;
      fhi_q     <= `VCMS_RST_FHI;
      isep_q    <= 1'b0;
      exkp_q    <= `VCMS_RST_CURKP;
      exki_q    <= `VCMS_RST_CURKI;
      tqkp_q    <= `VCMS_RST_CURKP;
      tqki_q    <= `VCMS_RST_CURKI;
      mlsrc_q   <= 3'd0;
      blsrc_q   <= 3'd0;
      mlval_q   <= `VCMS_RST_LIMVAL;
      blval_q   <= `VCMS_RST_LIMVAL;
      slip_q    <= `VCMS_RST_SLIP;
      fwmode_q  <= `VCMS_RST_FWMODE;
      fwdepth_q <= `VCMS_RST_FWDEPTH;
      fwmax_q   <= `VCMS_RST_FWMAX;
      fwgain_q  <= `VCMS_RST_FWGAIN;
      fwmult_q  <= `VCMS_RST_FWMULT;
      trsrc_q   <= 3'd0;
      trval_q   <= `VCMS_RST_TRVAL;
      ctrl_q    <= 3'b001;
      fmax_q    <= `VCMS_RST_FMAX;
    end
    else if (wr_en)
    begin
      if (PADDR_I == `VCMS_OFF_MODE)
        mode_q <= PWDATA_I[0];
      else if (PADDR_I == `VCMS_OFF_KP_SET1)
        kp_set1_q <= clampu(wd, `VCMS_KP_MIN, `VCMS_KP_MAX);
      else if (PADDR_I == `VCMS_OFF_TI_SET1)
        ti_set1_q <= clampu(wd, `VCMS_KP_MIN, `VCMS_KP_MAX);
      else if (PADDR_I == `VCMS_OFF_FLO)
        flo_q <= (wd > fhi_q) ? fhi_q : wd;
      else if (PADDR_I == `VCMS_OFF_KP2)
        kp2_q <= clampu(wd, `VCMS_KP_MIN, `VCMS_KP_MAX);
      else if (PADDR_I == `VCMS_OFF_TI2)
        ti2_q <= clampu(wd, `VCMS_KP_MIN, `VCMS_KP_MAX);
      else if (PADDR_I == `VCMS_OFF_FHI)
        fhi_q <= clampu(wd, flo_q, fmax_q);
      else if (PADDR_I == `VCMS_OFF_ISEP)
        isep_q <= PWDATA_I[0];
      else if (PADDR_I == `VCMS_OFF_EXKP)
        exkp_q <= clampu(wd, 16'd0, `VCMS_CUR_MAX);
      else if (PADDR_I == `VCMS_OFF_EXKI)
        exki_q <= clampu(wd, 16'd0, `VCMS_CUR_MAX);
      else if (PADDR_I == `VCMS_OFF_TQKP)
        tqkp_q <= clampu(wd, 16'd0, `VCMS_CUR_MAX);
      else if (PADDR_I == `VCMS_OFF_TQKI)
        tqki_q <= clampu(wd, 16'd0, `VCMS_CUR_MAX);
      else if (PADDR_I == `VCMS_OFF_MLSRC)
        mlsrc_q <= (PWDATA_I[2:0] > `VCMS_SRC_MAX) ? `VCMS_SRC_MAX : PWDATA_I[2:0];
      else if (PADDR_I == `VCMS_OFF_BLSRC)
        blsrc_q <= (PWDATA_I[2:0] > `VCMS_SRC_MAX) ? `VCMS_SRC_MAX : PWDATA_I[2:0];
      else if (PADDR_I == `VCMS_OFF_MLVAL)
        mlval_q <= clampu(wd, 16'd0, `VCMS_LIM_MAX);
      else if (PADDR_I == `VCMS_OFF_BLVAL)
        blval_q <= clampu(wd, 16'd0, `VCMS_LIM_MAX);
      else if (PADDR_I == `VCMS_OFF_SLIP)
        slip_q <= clampu(wd, `VCMS_SLIP_MIN, `VCMS_SLIP_MAX);
      else if (PADDR_I == `VCMS_OFF_FWMODE)
        fwmode_q <= (PWDATA_I[1:0] == 2'd3) ? 2'd2 : PWDATA_I[1:0];
      else if (PADDR_I == `VCMS_OFF_FWDEPTH)
        fwdepth_q <= clampu(wd, `VCMS_FWD_MIN, `VCMS_FWD_MAX);
      else if (PADDR_I == `VCMS_OFF_FWMAX)
        fwmax_q <= clampu(wd, `VCMS_FWM_MIN, `VCMS_FWM_MAX);
      else if (PADDR_I == `VCMS_OFF_FWGAIN)
        fwgain_q <= clampu(wd, `VCMS_FWG_MIN, `VCMS_FWG_MAX);
      else if (PADDR_I == `VCMS_OFF_FWMULT)
        fwmult_q <= (PWDATA_I[3:0] < `VCMS_MUL_MIN) ? `VCMS_MUL_MIN :
                    ((PWDATA_I[3:0] > `VCMS_MUL_MAX) ? `VCMS_MUL_MAX : PWDATA_I[3:0]);
      else if (PADDR_I == `VCMS_OFF_TRSRC)
        trsrc_q <= PWDATA_I[2:0];
      else if (PADDR_I == `VCMS_OFF_TRVAL)
        trval_q <= ($signed(wd) > `VCMS_TRQ_MAX) ? `VCMS_TRQ_MAX :
                   (($signed(wd) < -`VCMS_TRQ_MAX) ? -`VCMS_TRQ_MAX : wd);
      else if (PADDR_I == `VCMS_OFF_CTRL)
        ctrl_q <= PWDATA_I[2:0];
    end
  end

  // ==========================================================================
  // Pin synchronisers: three stages, change accepted once stages 2 and 3 agree
  reg [2:0] swap_s_q, inh_s_q;
  reg       swap_q, inh_q;
  always @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      swap_s_q <= 3'b000;
      inh_s_q  <= 3'b000;
      swap_q   <= 1'b0;
      inh_q    <= 1'b0;
    end
    else
    begin
      swap_s_q <= {swap_s_q[1:0], MODE_SWAP_I};
      inh_s_q  <= {inh_s_q[1:0], TORQUE_INHIBIT_I};
      if (swap_s_q[1] == swap_s_q[2])
        swap_q <= swap_s_q[2];
      if (inh_s_q[1] == inh_s_q[2])
        inh_q <= inh_s_q[2];
    end
  end

  // ==========================================================================
  // Control cycle timer; snapshot at cycle start avoids half-written gain sets
  reg [7:0] cyc_q;
  wire      cyc_start = (cyc_q == 8'd0);
  always @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      cyc_q <= 8'd0;
    else
      cyc_q <= cyc_start ? (`VCMS_CYC_LEN - 8'd1) : (cyc_q - 8'd1);
  end

  // ==========================================================================
  // Combinational selection
  wire active = ctrl_q[`VCMS_CTRL_EN] & ~ctrl_q[`VCMS_CTRL_VF] & ~ctrl_q[`VCMS_CTRL_M2];
  wire torque_mode = ~inh_q & (mode_q ^ swap_q);

  // Linear interpolation of one gain between the switchover points
  function [15:0] interp;
    input [15:0] f;
    input [15:0] lo;
    input [15:0] hi;
    input [15:0] a;
    input [15:0] b;
    reg   [31:0] num;
    reg   [16:0] span;
    reg   [16:0] diff;
    begin
      span = {1'b0, hi} - {1'b0, lo};
      if (f <= lo)
        interp = a;
      else if (f >= hi)
        interp = b;
      else if (b >= a)
      begin
        diff = {1'b0, b} - {1'b0, a};
        num = (diff[15:0] * (f - lo)) / span[15:0];
        interp = a + num[15:0];
      end
      else
      begin
        diff = {1'b0, a} - {1'b0, b};
        num = (diff[15:0] * (f - lo)) / span[15:0];
        interp = a - num[15:0];
      end
    end
  endfunction

  // Percentage scaling: full-scale input maps to the digital value
  function [15:0] scale;
    input [15:0] src;
    input [15:0] full;
    reg   [31:0] p;
    begin
      p = (src * full) / {16'd0, `VCMS_FULL_SCALE};
      scale = p[15:0];
    end
  endfunction

  function [15:0] lim_sel;
    input [2:0]  code;
    input [15:0] dig;
    input [15:0] a;
    input [15:0] b;
    input [15:0] c;
    input [15:0] p;
    input [15:0] m;
    begin
      if (code == 3'd0)
        lim_sel = dig;
      else if (code == 3'd1)
        lim_sel = scale(a, dig);
      else if (code == 3'd2)
        lim_sel = scale(b, dig);
      else if (code == 3'd3)
        lim_sel = scale(c, dig);
      else if (code == 3'd4)
        lim_sel = scale(p, dig);
      else
        lim_sel = scale(m, dig);
    end
  endfunction

  wire [15:0] kp_w  = interp(RUN_FREQ_I, flo_q, fhi_q, kp_set1_q, kp2_q);
  wire [15:0] ti_w  = interp(RUN_FREQ_I, flo_q, fhi_q, ti_set1_q, ti2_q);
  wire [15:0] ml_w  = lim_sel(mlsrc_q, mlval_q, ANALOG_IN_A_I, ANALOG_IN_B_I,
                              ANALOG_IN_C_I, PULSE_INPUT_I, COMM_LIMIT_I);
  wire [15:0] bl_w  = lim_sel(blsrc_q, blval_q, ANALOG_IN_A_I, ANALOG_IN_B_I,
                              ANALOG_IN_C_I, PULSE_INPUT_I, COMM_LIMIT_I);
  wire [15:0] ai_min = (ANALOG_IN_A_I < ANALOG_IN_B_I) ? ANALOG_IN_A_I : ANALOG_IN_B_I;
  wire [15:0] ai_max = (ANALOG_IN_A_I < ANALOG_IN_B_I) ? ANALOG_IN_B_I : ANALOG_IN_A_I;

  // Torque reference: magnitude scaled from source, sign from digital setting
  reg  [15:0] tr_src;
  always @*
  begin
    if (trsrc_q == 3'd1)
      tr_src = ANALOG_IN_A_I;
    else if (trsrc_q == 3'd2)
      tr_src = ANALOG_IN_B_I;
    else if (trsrc_q == 3'd3)
      tr_src = ANALOG_IN_C_I;
    else if (trsrc_q == 3'd4)
      tr_src = PULSE_INPUT_I;
    else if (trsrc_q == 3'd5)
      tr_src = COMM_TORQUE_I;
    else if (trsrc_q == 3'd6)
      tr_src = ai_min;
    else
      tr_src = ai_max;
  end
  wire        tr_neg = trval_q[15];
  wire [15:0] tr_mag = tr_neg ? (16'd0 - trval_q) : trval_q;
  wire [15:0] tr_sc  = (trsrc_q == 3'd0) ? tr_mag : scale(tr_src, tr_mag);
  wire [15:0] tr_w   = tr_neg ? (16'd0 - tr_sc) : tr_sc;

  // Field weakening current: depth scaling in direct mode, then max clamp
  wire [31:0] fw_prod = FW_CALC_CURRENT_I * fwdepth_q;
  wire [31:0] fw_dir  = fw_prod / 32'd100;
  wire [15:0] fw_raw  = (fwmode_q == 2'd0) ? 16'd0 :
                        ((fwmode_q == 2'd1) ? ((fw_dir > {16'd0, fwmax_q}) ? fwmax_q :
                         fw_dir[15:0]) : FW_CALC_CURRENT_I);
  wire [15:0] fw_w    = (fw_raw > fwmax_q) ? fwmax_q : fw_raw;

  // ==========================================================================
  // Output registers, updated once per control cycle while active; otherwise mode, limits, reference, field current and direction forced idle each clock, rest held
  always @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      TORQUE_MODE_O    <= 1'b0;
      SPEED_KP_O       <= 16'h0000;
      SPEED_TI_O       <= 16'h0000;
      INTEGRAL_SEP_O   <= 1'b0;
      EXCIT_KP_O       <= 16'h0000;
      EXCIT_KI_O       <= 16'h0000;
      TORQUE_KP_O      <= 16'h0000;
      TORQUE_KI_O      <= 16'h0000;
      MOTORING_LIMIT_O <= 16'h0000;
      BRAKING_LIMIT_O  <= 16'h0000;
      SLIP_GAIN_O      <= 16'h0000;
      FW_MODE_O        <= 2'd0;
      FW_CURRENT_O     <= 16'h0000;
      FW_ADAPT_GAIN_O  <= 16'h0000;
      FW_MULT_O        <= 4'h0;
      TORQUE_REF_O     <= 16'h0000;
      REVERSE_O        <= 1'b0;
      CYCLE_START_O    <= 1'b0;
    end
    else
    begin
      CYCLE_START_O <= cyc_start & active;
      if (!active)
      begin
        // Idle outputs keep the downstream loops from acting on stale settings
        TORQUE_MODE_O    <= 1'b0;
        MOTORING_LIMIT_O <= 16'h0000;
        BRAKING_LIMIT_O  <= 16'h0000;
        TORQUE_REF_O     <= 16'h0000;
        FW_CURRENT_O     <= 16'h0000;
        REVERSE_O        <= 1'b0;
      end
      else if (cyc_start)
      begin
        TORQUE_MODE_O    <= torque_mode;
        SPEED_KP_O       <= kp_w;
        SPEED_TI_O       <= ti_w;
        INTEGRAL_SEP_O   <= isep_q;
        EXCIT_KP_O       <= exkp_q;
        EXCIT_KI_O       <= exki_q;
        TORQUE_KP_O      <= tqkp_q;
        TORQUE_KI_O      <= tqki_q;
        MOTORING_LIMIT_O <= torque_mode ? 16'h0000 : ml_w;
        BRAKING_LIMIT_O  <= torque_mode ? 16'h0000 : bl_w;
        SLIP_GAIN_O      <= slip_q;
        FW_MODE_O        <= fwmode_q;
        FW_CURRENT_O     <= fw_w;
        FW_ADAPT_GAIN_O  <= fwgain_q;
        FW_MULT_O        <= fwmult_q;
        TORQUE_REF_O     <= torque_mode ? tr_w : 16'h0000;
        REVERSE_O        <= torque_mode & tr_w[15];
      end
    end
  end

  // ==========================================================================
  // APB read path, zero wait states; unmapped addresses answer with an error
  reg [31:0] rd;
  reg        rd_err;
  always @*
  begin
    rd_err = 1'b0;
    if (PADDR_I == `VCMS_OFF_MODE)         rd = {31'd0, mode_q};
    else if (PADDR_I == `VCMS_OFF_KP_SET1) rd = {16'd0, kp_set1_q};
    else if (PADDR_I == `VCMS_OFF_TI_SET1) rd = {16'd0, ti_set1_q};
    else if (PADDR_I == `VCMS_OFF_FLO)     rd = {16'd0, flo_q};
    else if (PADDR_I == `VCMS_OFF_KP2)     rd = {16'd0, kp2_q};
    else if (PADDR_I == `VCMS_OFF_TI2)     rd = {16'd0, ti2_q};
    else if (PADDR_I == `VCMS_OFF_FHI)     rd = {16'd0, fhi_q};
    else if (PADDR_I == `VCMS_OFF_ISEP)    rd = {31'd0, isep_q};
    else if (PADDR_I == `VCMS_OFF_EXKP)    rd = {16'd0, exkp_q};
    else if (PADDR_I == `VCMS_OFF_EXKI)    rd = {16'd0, exki_q};
    else if (PADDR_I == `VCMS_OFF_TQKP)    rd = {16'd0, tqkp_q};
    else if (PADDR_I == `VCMS_OFF_TQKI)    rd = {16'd0, tqki_q};
    else if (PADDR_I == `VCMS_OFF_MLSRC)   rd = {29'd0, mlsrc_q};
    else if (PADDR_I == `VCMS_OFF_BLSRC)   rd = {29'd0, blsrc_q};
    else if (PADDR_I == `VCMS_OFF_MLVAL)   rd = {16'd0, mlval_q};
    else if (PADDR_I == `VCMS_OFF_BLVAL)   rd = {16'd0, blval_q};
    else if (PADDR_I == `VCMS_OFF_SLIP)    rd = {16'd0, slip_q};
    else if (PADDR_I == `VCMS_OFF_FWMODE)  rd = {30'd0, fwmode_q};
    else if (PADDR_I == `VCMS_OFF_FWDEPTH) rd = {16'd0, fwdepth_q};
    else if (PADDR_I == `VCMS_OFF_FWMAX)   rd = {16'd0, fwmax_q};
    else if (PADDR_I == `VCMS_OFF_FWGAIN)  rd = {16'd0, fwgain_q};
    else if (PADDR_I == `VCMS_OFF_FWMULT)  rd = {28'd0, fwmult_q};
    else if (PADDR_I == `VCMS_OFF_TRSRC)   rd = {29'd0, trsrc_q};
    else if (PADDR_I == `VCMS_OFF_TRVAL)   rd = {16'd0, trval_q};
    else if (PADDR_I == `VCMS_OFF_CTRL)    rd = {29'd0, ctrl_q};
    else if (PADDR_I == `VCMS_OFF_STATUS)
      rd = {27'd0, (RUN_FREQ_I > flo_q) & (RUN_FREQ_I < fhi_q),
            RUN_FREQ_I >= fhi_q, REVERSE_O, TORQUE_MODE_O, active};
    else if (PADDR_I == `VCMS_OFF_SPDKP)   rd = {16'd0, SPEED_KP_O};
    else if (PADDR_I == `VCMS_OFF_SPDTI)   rd = {16'd0, SPEED_TI_O};
    else if (PADDR_I == `VCMS_OFF_MLIM)    rd = {16'd0, MOTORING_LIMIT_O};
    else if (PADDR_I == `VCMS_OFF_BLIM)    rd = {16'd0, BRAKING_LIMIT_O};
    else if (PADDR_I == `VCMS_OFF_TQREF)   rd = {16'd0, TORQUE_REF_O};
    else if (PADDR_I == `VCMS_OFF_FWLIM)   rd = {16'd0, FW_CURRENT_O};
    else
    begin
      rd = 32'h0000_0000;
      rd_err = 1'b1;
    end
  end

  // Registered answer: pready rises with the access phase, high in its first cycle
  always @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & rd_err;
      PRDATA_O  <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rd : 32'h0000_0000;
    end
  end

endmodule

// [vcms_top_properties.sv]
// Port checker for the vector mode selector
module vcms_properties
(
  // Clock, reset and bus
  input wire        CLK_SYS_I,
  input wire        RESETN_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  input wire [31:0] PRDATA_O,
  // Control results
  input wire        TORQUE_MODE_O,
  input wire [15:0] MOTORING_LIMIT_O,
  input wire [15:0] BRAKING_LIMIT_O,
  input wire [15:0] TORQUE_REF_O,
  input wire        REVERSE_O,
  input wire [15:0] SPEED_KP_O,
  input wire [15:0] SPEED_TI_O,
  input wire        CYCLE_START_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  // ==========================================
  // Bus and control relations
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> PREADY_O)
    else $error("no ready after setup");
  chk_ready_one: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  chk_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  chk_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside ready");
  chk_limit_torque: assert property (TORQUE_MODE_O |-> MOTORING_LIMIT_O == 16'h0 && BRAKING_LIMIT_O == 16'h0)
    else $error("limits nonzero in torque mode");
  chk_ref_speed: assert property (!TORQUE_MODE_O |-> TORQUE_REF_O == 16'h0)
    else $error("reference nonzero in speed mode");
  chk_reverse_sign: assert property (REVERSE_O == TORQUE_REF_O[15])
    else $error("direction differs from sign");
  chk_gain_hold: assert property (!CYCLE_START_O |-> $stable(SPEED_KP_O) && $stable(SPEED_TI_O))
    else $error("gain changed mid cycle");
  chk_cycle_gap: assert property (CYCLE_START_O |=> !CYCLE_START_O [*8])
    else $error("cycle starts too close");
endmodule
